// [logic/lpps_consts.svh]
// Constants for the panel power sequencer: register offsets, reset values and widths.
`ifndef LPPS_CONSTS_SVH
`define LPPS_CONSTS_SVH
`define LPPS_ADDR_CTRL 12'h000
`define LPPS_ADDR_STATUS 12'h004
`define LPPS_ADDR_UP_DLY 12'h008
`define LPPS_ADDR_LAMP_DLY 12'h00c
`define LPPS_ADDR_LOFF_DLY 12'h010
`define LPPS_ADDR_SOFF_DLY 12'h014
`define LPPS_ADDR_CYC_DLY 12'h018
`define LPPS_DLY_W 20
`define LPPS_DLY_RESET 20'h003e8
`define LPPS_DLY_MIN 20'h00001
`define LPPS_CTRL_ON_BIT 0
`define LPPS_ST_SUPPLY_BIT 0
`define LPPS_ST_LINK_BIT 1
`define LPPS_ST_LAMP_BIT 2
`define LPPS_ST_WAIT_BIT 3
`define LPPS_ST_STATE_LSB 4
`endif

// [logic/lpps_pkg.sv]
// Types shared by the panel power sequencer.
package lpps_pkg;
   typedef enum logic [2:0] {
      LPPS_OFF = 3'b000,
      LPPS_UP_SUPPLY = 3'b001,
      LPPS_UP_LINK = 3'b010,
      LPPS_ON = 3'b011,
      LPPS_DN_LAMP = 3'b100,
      LPPS_DN_LINK = 3'b101
   } lpps_state_t;
   typedef struct packed {
      logic supply;
      logic link;
      logic lamp;
   } lpps_pins_t;
endpackage

// [logic/lpps_sequencer.sv]
// Panel power sequencer with an APB register interface.
//
// Local design decisions: the APB register port and the placing of the registers.
`include "lpps_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module lpps_sequencer
   import lpps_pkg::*;
#(
   parameter int DLY_W = `LPPS_DLY_W
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic panel_supply_enable,
   output logic lamp_supply_enable,
   output logic link_enable
);
   logic on_req_r;
   logic [DLY_W-1:0] up_dly_r;
   logic [DLY_W-1:0] lamp_dly_r;
   logic [DLY_W-1:0] loff_dly_r;
   logic [DLY_W-1:0] soff_dly_r;
   logic [DLY_W-1:0] cyc_dly_r;
   logic [DLY_W-1:0] cnt_r;
   logic [DLY_W-1:0] cnt_nxt;
   logic [DLY_W-1:0] cyc_cnt_r;
   logic [DLY_W-1:0] cyc_cnt_nxt;
   lpps_state_t state_r;
   lpps_state_t state_nxt;
   lpps_pins_t pins_r;
   lpps_pins_t pins_nxt;
   logic [31:0] prdata_nxt;
   logic pslverr_nxt;
   logic [DLY_W-1:0] step_age_r;
   logic [DLY_W-1:0] step_age_nxt;

   // APB decode: access phase strobes and address hits.
   wire logic acc = psel & penable & ~pready;
   wire logic wr = psel & penable & pwrite & pready; // Writes land as the access completes.
   wire logic hit_ctrl = (paddr == `LPPS_ADDR_CTRL);
   wire logic hit_stat = (paddr == `LPPS_ADDR_STATUS);
   wire logic hit_up = (paddr == `LPPS_ADDR_UP_DLY);
   wire logic hit_lamp = (paddr == `LPPS_ADDR_LAMP_DLY);
   wire logic hit_loff = (paddr == `LPPS_ADDR_LOFF_DLY);
   wire logic hit_soff = (paddr == `LPPS_ADDR_SOFF_DLY);
   wire logic hit_cyc = (paddr == `LPPS_ADDR_CYC_DLY);
   wire logic hit_any = hit_ctrl | hit_stat | hit_up | hit_lamp | hit_loff | hit_soff | hit_cyc;
   wire logic cyc_done = (cyc_cnt_r == '0);
   wire logic cnt_done = (cnt_r == '0);
   wire logic [DLY_W-1:0] one = DLY_W'(`LPPS_DLY_MIN);
   wire logic [31:0] status_word = {25'h0000000, state_r, cyc_done ? 1'b0 : 1'b1,
                                    pins_r.lamp, pins_r.link, pins_r.supply};

   // Read mux; unmapped addresses read zero and flag an error.
   assign prdata_nxt = !acc || pwrite ? 32'h00000000 :
                       hit_ctrl ? {31'h00000000, on_req_r} :
                       hit_stat ? status_word :
                       hit_up ? 32'(up_dly_r) :
                       hit_lamp ? 32'(lamp_dly_r) :
                       hit_loff ? 32'(loff_dly_r) :
                       hit_soff ? 32'(soff_dly_r) :
                       hit_cyc ? 32'(cyc_dly_r) : 32'h00000000;
   assign pslverr_nxt = acc & ~hit_any;

   // Bus answer registers: one wait state, answer in the second access cycle.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         prdata <= 32'h00000000;
         pslverr <= 1'b0;
      end else begin
         pready <= acc;
         prdata <= prdata_nxt;
         pslverr <= pslverr_nxt;
      end
   end

   // Software-loaded request bit and intervals; a zero interval is stored as one cycle.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         on_req_r <= 1'b0;
         up_dly_r <= DLY_W'(`LPPS_DLY_RESET);
         lamp_dly_r <= DLY_W'(`LPPS_DLY_RESET);
         loff_dly_r <= DLY_W'(`LPPS_DLY_RESET);
         soff_dly_r <= DLY_W'(`LPPS_DLY_RESET);
         cyc_dly_r <= DLY_W'(`LPPS_DLY_RESET);
      end else if (wr) begin
         if (hit_ctrl) on_req_r <= pwdata[`LPPS_CTRL_ON_BIT];
         if (hit_up) up_dly_r <= (pwdata[DLY_W-1:0] == '0) ? one : pwdata[DLY_W-1:0];
         if (hit_lamp) lamp_dly_r <= (pwdata[DLY_W-1:0] == '0) ? one : pwdata[DLY_W-1:0];
         if (hit_loff) loff_dly_r <= (pwdata[DLY_W-1:0] == '0) ? one : pwdata[DLY_W-1:0];
         if (hit_soff) soff_dly_r <= (pwdata[DLY_W-1:0] == '0) ? one : pwdata[DLY_W-1:0];
         if (hit_cyc) cyc_dly_r <= (pwdata[DLY_W-1:0] == '0) ? one : pwdata[DLY_W-1:0];
      end
   end

   // Sequencer next state: each timed step waits out its interval counter before moving on, except that a cleared request ends a power-up step at once.
   always_comb begin
      state_nxt = state_r;
      pins_nxt = pins_r;
      cnt_nxt = cnt_done ? cnt_r : cnt_r - one;
      cyc_cnt_nxt = cyc_done ? cyc_cnt_r : cyc_cnt_r - one;
      case (state_r)
         LPPS_OFF: begin
            if (on_req_r && cyc_done) begin
               state_nxt = LPPS_UP_SUPPLY;
               pins_nxt.supply = 1'b1;
               cnt_nxt = up_dly_r;
            end
         end
         LPPS_UP_SUPPLY: begin
            if (!on_req_r) begin
               state_nxt = LPPS_DN_LINK;
               cnt_nxt = soff_dly_r;
            end else if (cnt_done) begin
               state_nxt = LPPS_UP_LINK;
               pins_nxt.link = 1'b1;
               cnt_nxt = lamp_dly_r;
            end
         end
         LPPS_UP_LINK: begin
            if (!on_req_r) begin
               state_nxt = LPPS_DN_LINK;
               pins_nxt.link = 1'b0;
               cnt_nxt = soff_dly_r;
            end else if (cnt_done) begin
               state_nxt = LPPS_ON;
               pins_nxt.lamp = 1'b1;
            end
         end
         LPPS_ON: begin
            if (!on_req_r) begin
               state_nxt = LPPS_DN_LAMP;
               pins_nxt.lamp = 1'b0;
               cnt_nxt = loff_dly_r;
            end
         end
         LPPS_DN_LAMP: begin
            if (cnt_done) begin
               state_nxt = LPPS_DN_LINK;
               pins_nxt.link = 1'b0;
               cnt_nxt = soff_dly_r;
            end
         end
         LPPS_DN_LINK: begin
            if (cnt_done) begin
               state_nxt = LPPS_OFF;
               pins_nxt.supply = 1'b0;
               cyc_cnt_nxt = cyc_dly_r;
            end
         end
         default: begin
            state_nxt = LPPS_OFF;
            pins_nxt = '0;
         end
      endcase
   end

   // Sequencer registers; reset leaves everything off with no cycle wait pending.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= LPPS_OFF;
         pins_r <= '0;
         cnt_r <= '0;
         cyc_cnt_r <= '0;
      end else begin
         state_r <= state_nxt;
         pins_r <= pins_nxt;
         cnt_r <= cnt_nxt;
         cyc_cnt_r <= cyc_cnt_nxt;
      end
   end

   // Cycles since any panel enable last changed; it saturates and starts full after reset,
   // so the checks below see the power-cycle wait as already met.
   wire logic pins_change = (pins_nxt != pins_r);
   wire logic age_full = (step_age_r == '1);
   assign step_age_nxt = pins_change ? '0 : (age_full ? step_age_r : step_age_r + one);

   // Age register for the interval checks; it never feeds the sequencer itself.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         step_age_r <= '1;
      end else begin
         step_age_r <= step_age_nxt;
      end
   end

   // Only the sequencer drives the panel pins, each straight from a flip-flop.
   assign panel_supply_enable = pins_r.supply;
   assign lamp_supply_enable = pins_r.lamp;
   assign link_enable = pins_r.link;

   // Ordering checks tied to the sequencer's own state and counters.
   a_link_needs_supply: assert property (@(posedge pclk) disable iff (!presetn)
      link_enable |-> panel_supply_enable)
      else $error("Link driven without panel supply.");
   a_lamp_needs_link: assert property (@(posedge pclk) disable iff (!presetn)
      lamp_supply_enable |-> link_enable)
      else $error("Lamp on without active link.");
   a_link_start_wait: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(link_enable) |-> $past(state_r) == LPPS_UP_SUPPLY && $past(cnt_r) == '0)
      else $error("Link started before supply interval ended.");
   a_lamp_on_wait: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(lamp_supply_enable) |-> $past(state_r) == LPPS_UP_LINK && $past(cnt_r) == '0)
      else $error("Lamp enabled before link interval ended.");
   a_link_stop_wait: assert property (@(posedge pclk) disable iff (!presetn)
      $fell(link_enable) && $past(state_r) == LPPS_DN_LAMP |-> $past(cnt_r) == '0)
      else $error("Link stopped before lamp-off interval ended.");
   a_supply_off_wait: assert property (@(posedge pclk) disable iff (!presetn)
      $fell(panel_supply_enable) |-> $past(state_r) == LPPS_DN_LINK && $past(cnt_r) == '0
      && !link_enable)
      else $error("Supply removed before link-off interval ended.");
   a_cycle_wait_load: assert property (@(posedge pclk) disable iff (!presetn)
      $fell(panel_supply_enable) |-> cyc_cnt_r == $past(cyc_dly_r))
      else $error("Power cycle wait not loaded at supply off.");
   a_cycle_wait_hold: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(panel_supply_enable) |-> $past(cyc_cnt_r) == '0)
      else $error("Power-up started during power cycle wait.");
   a_interval_nonzero: assert property (@(posedge pclk) disable iff (!presetn)
      up_dly_r != '0 && lamp_dly_r != '0 && loff_dly_r != '0 && soff_dly_r != '0
      && cyc_dly_r != '0)
      else $error("Interval register holds zero.");
   a_abort_reverse: assert property (@(posedge pclk) disable iff (!presetn)
      state_r == LPPS_UP_LINK && !on_req_r |=> state_r == LPPS_DN_LINK && !link_enable
      && cnt_r == $past(soff_dly_r))
      else $error("Aborted power-up did not reverse correctly.");

   // An abort while the supply settles goes straight to the supply-off wait.
   a_abort_early: assert property (@(posedge pclk) disable iff (!presetn)
      state_r == LPPS_UP_SUPPLY && !on_req_r |=> state_r == LPPS_DN_LINK && !link_enable
      && cnt_r == $past(soff_dly_r))
      else $error("Power-up aborted in supply wait did not reverse correctly.");

   // The link starts only after the supply has stood for the whole interval.
   a_link_up_age: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(link_enable) |-> $past(step_age_r) >= $past(up_dly_r))
      else $error("Link started too soon after supply on.");

   // The lamp comes on only after the link has run for the whole interval.
   a_lamp_up_age: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(lamp_supply_enable) |-> $past(step_age_r) >= $past(lamp_dly_r))
      else $error("Lamp enabled too soon after link start.");

   // On power-down the link stops only after the lamp-off interval.
   a_link_down_age: assert property (@(posedge pclk) disable iff (!presetn)
      $fell(link_enable) && $past(state_r) == LPPS_DN_LAMP |-> $past(step_age_r) >= $past(loff_dly_r))
      else $error("Link stopped too soon after lamp off.");

   // The supply drops only after the last change has stood for the link-off interval.
   a_supply_down_age: assert property (@(posedge pclk) disable iff (!presetn)
      $fell(panel_supply_enable) |-> $past(step_age_r) >= $past(soff_dly_r))
      else $error("Supply removed too soon after link off.");

   // The supply returns only after the power-cycle wait has run out.
   a_cycle_wait_age: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(panel_supply_enable) |-> $past(step_age_r) >= $past(cyc_dly_r))
      else $error("Supply enabled again too soon after supply off.");

   // While idle every panel enable is low.
   a_off_all_low: assert property (@(posedge pclk) disable iff (!presetn)
      state_r == LPPS_OFF |-> !panel_supply_enable && !link_enable && !lamp_supply_enable)
      else $error("Panel enable high while sequencer is off.");

   // Fully on means supply, link and lamp are all driven.
   a_on_all_high: assert property (@(posedge pclk) disable iff (!presetn)
      state_r == LPPS_ON |-> panel_supply_enable && link_enable && lamp_supply_enable)
      else $error("Panel enable low while sequencer is on.");

   // The lamp stays off throughout power-down.
   a_down_lamp_low: assert property (@(posedge pclk) disable iff (!presetn)
      state_r == LPPS_DN_LAMP || state_r == LPPS_DN_LINK |-> !lamp_supply_enable)
      else $error("Lamp on during power-down.");

   // Each access gets a single-cycle ready pulse.
   a_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
      pready |=> !pready)
      else $error("Ready held for more than one cycle.");

   // An error is only flagged together with ready.
   a_error_needs_ready: assert property (@(posedge pclk) disable iff (!presetn)
      pslverr |-> pready)
      else $error("Error flagged without ready.");

   // Read data rests at zero outside the answer cycle.
   a_idle_data_zero: assert property (@(posedge pclk) disable iff (!presetn)
      !pready |-> prdata == 32'h00000000)
      else $error("Read data not zero outside the answer cycle.");
endmodule
`default_nettype wire

// [test/lpps_panel_model.sv]
// Panel side model that timestamps every edge of the supply, link and lamp enables.
`timescale 1ns/1ps
`default_nettype none
module lpps_panel_model
   import lpps_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire lpps_pins_t pins,
   output var int t_on [3],
   output var int t_off [3],
   output var int link_rises,
   output var logic order_bad
);
   int cyc;
   lpps_pins_t prev;
   // Records edge times in cycles and flags a lamp on without the link or a link on without the supply.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cyc <= 0;
         prev <= '0;
         link_rises <= 0;
         order_bad <= 1'b0;
      end else begin
         cyc <= cyc + 1;
         prev <= pins;
         for (int i = 0; i < 3; i++) begin
            if (pins[i] && !prev[i]) t_on[i] <= cyc;
            if (!pins[i] && prev[i]) t_off[i] <= cyc;
         end
         if (pins.link && !prev.link) link_rises <= link_rises + 1;
         if ((pins.lamp && !pins.link) || (pins.link && !pins.supply)) order_bad <= 1'b1;
      end
   end
endmodule
`default_nettype wire

// [test/lpps_sequencer_tb.sv]
// Testbench for the panel power sequencer, driven over APB.
`include "lpps_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module lpps_sequencer_tb;
   import lpps_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [31:0] prdata;
   logic [31:0] rd;
   logic pready;
   logic pslverr;
   logic order_bad;
   lpps_pins_t pins;
   int t_on [3];
   int t_off [3];
   int link_rises;
   int miscompares = 0;
   int compares = 0;
   int dly [5] = '{12, 7, 4, 6, 30};
   // Clock of 100 ns period.
   always #50 pclk = ~pclk;
   lpps_sequencer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .panel_supply_enable(pins.supply), .lamp_supply_enable(pins.lamp),
      .link_enable(pins.link));
   lpps_panel_model panel (.pclk(pclk), .presetn(presetn), .pins(pins), .t_on(t_on),
      .t_off(t_off), .link_rises(link_rises), .order_bad(order_bad));
   // Prints the verdict and ends the run.
   task automatic report_and_stop();
      if (miscompares == 0 && compares > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // Compares one value and reports a mismatch.
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   // One APB transfer; holds the request until pready is seen high at an edge.
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
      input logic err);
      int n;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         miscompares++;
         report_and_stop();
      end
      rd = prdata;
      check("pslverr", 32'(err), 32'(pslverr));
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   // Waits, under a bound, until the enables show the wanted pattern.
   task automatic wait_pins(input lpps_pins_t want);
      int n;
      n = 0;
      while (pins !== want && n < 5000) begin
         @(posedge pclk);
         n++;
      end
      if (n >= 5000) begin
         miscompares++;
         report_and_stop();
      end
      repeat (2) @(posedge pclk);
   endtask
   // Main sequence: reset state, programming, power up, power down, cycle wait and abort.
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      check("pins after reset", 32'h0, 32'(pins));
      apb(1'b0, `LPPS_ADDR_STATUS, 32'h0, 1'b0);
      check("status after reset", 32'h0, rd);
      apb(1'b0, `LPPS_ADDR_CYC_DLY, 32'h0, 1'b0);
      check("cycle wait reset", 32'h3e8, rd);
      apb(1'b0, 12'h01c, 32'h0, 1'b1);
      check("unmapped read", 32'h0, rd);
      apb(1'b1, `LPPS_ADDR_UP_DLY, 32'h0, 1'b0);
      apb(1'b0, `LPPS_ADDR_UP_DLY, 32'h0, 1'b0);
      check("zero clamp", 32'h1, rd);
      foreach (dly[i]) apb(1'b1, `LPPS_ADDR_UP_DLY + 12'(4 * i), 32'(dly[i]), 1'b0);
      apb(1'b1, `LPPS_ADDR_CTRL, 32'h1, 1'b0);
      wait_pins(3'b111);
      check("supply to link", 32'(dly[0] + 1), 32'(t_on[1] - t_on[2]));
      check("link to lamp", 32'(dly[1] + 1), 32'(t_on[0] - t_on[1]));
      apb(1'b0, `LPPS_ADDR_STATUS, 32'h0, 1'b0);
      check("status on", 32'h37, rd);
      apb(1'b1, `LPPS_ADDR_CTRL, 32'h0, 1'b0);
      wait_pins(3'b000);
      check("lamp off to link off", 32'(dly[2] + 1), 32'(t_off[1] - t_off[0]));
      check("link off to supply off", 32'(dly[3] + 1), 32'(t_off[2] - t_off[1]));
      apb(1'b0, `LPPS_ADDR_STATUS, 32'h0, 1'b0);
      check("status cycle wait", 32'h8, rd);
      apb(1'b1, `LPPS_ADDR_CTRL, 32'h1, 1'b0);
      wait_pins(3'b100);
      check("cycle wait kept", 32'(dly[4] + 1), 32'(t_on[2] - t_off[2]));
      apb(1'b1, `LPPS_ADDR_CTRL, 32'h0, 1'b0);
      wait_pins(3'b000);
      check("abort link starts", 32'h1, 32'(link_rises));
      apb(1'b1, `LPPS_ADDR_LAMP_DLY, 32'h28, 1'b0);
      apb(1'b1, `LPPS_ADDR_CTRL, 32'h1, 1'b0);
      wait_pins(3'b110);
      apb(1'b1, `LPPS_ADDR_CTRL, 32'h0, 1'b0);
      wait_pins(3'b000);
      check("link wait abort starts", 32'h2, 32'(link_rises));
      check("lamp kept off", 32'h1, 32'(t_on[0] < t_off[0]));
      check("abort link off to supply off", 32'(dly[3] + 1), 32'(t_off[2] - t_off[1]));
      check("enable order", 32'h0, 32'(order_bad));
      report_and_stop();
   end
endmodule
`default_nettype wire
